// ==== hw/trig_in_pkg.sv ====
// constants, field layouts and state type of the trigger-input unit
// assumes a single 200 MHz system clock and a synchronous active-high reset
package trig_in_pkg;

    localparam int NUM_LINES = 4;
    localparam int NUM_GEN = 2;
    localparam int CFG_W = 7;

    // register byte offsets on the apb slave
    localparam logic [7:0] OFS_SETTING = 8'h00;
    localparam logic [7:0] OFS_ACTIVATE = 8'h04;
    localparam logic [7:0] OFS_REC_ARM = 8'h08;
    localparam logic [7:0] OFS_WG_MODE = 8'h0C;
    localparam logic [7:0] OFS_WG_RATE = 8'h10;
    localparam logic [7:0] OFS_WG_CYCLES = 8'h14;
    localparam logic [7:0] OFS_WG_LEN = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_CFG_VIEW = 8'h20;
    localparam logic [7:0] OFS_LAST = 8'h2C;

    // setting command word: value, setting id, line id
    localparam int SET_VAL_LSB = 0;
    localparam int SET_PARAM_LSB = 8;
    localparam int SET_LINE_LSB = 16;

    // line_setting_id codes
    localparam logic [7:0] PARAM_EDGE_LEVEL = 8'h01;
    localparam logic [7:0] PARAM_FUNCTION = 8'h03;
    localparam logic [7:0] PARAM_POLARITY = 8'h07;
    localparam logic [7:0] PARAM_GEN_MASK = 8'h0D;

    // packed per-line configuration fields
    localparam int CFG_TYPE_BIT = 0;
    localparam int CFG_FUNC_LSB = 1;
    localparam int CFG_POL_BIT = 4;
    localparam int CFG_MASK_LSB = 5;

    localparam logic TYPE_EDGE = 1'b0;
    localparam logic TYPE_LEVEL = 1'b1;
    localparam logic [2:0] FUNC_NONE = 3'h0;
    localparam logic [2:0] FUNC_CAPTURE = 3'h2;
    localparam logic [2:0] FUNC_WAVE = 3'h4;
    localparam logic [7:0] MASK_MAX = 8'h03;

    // wavegen_start_mode bit for start by external trigger
    localparam int WG_EXT_START_BIT = 1;

    // status and recorder register fields
    localparam int STAT_DONE_LSB = 4;
    localparam int STAT_BUSY_BIT = 6;
    localparam int STAT_ERR_BIT = 7;
    localparam int REC_ARM_BIT = 3;
    localparam int REC_BUSY_BIT = 4;
    localparam int VIEW_ACTIVE_LSB = 16;

    typedef struct packed {
        logic [NUM_LINES-1:0] sync1;
        logic [NUM_LINES-1:0] sync2;
        logic [NUM_LINES-1:0] act_prev;
        logic [NUM_LINES-1:0][CFG_W-1:0] staged;
        logic [NUM_LINES-1:0][CFG_W-1:0] active;
        logic [NUM_LINES-1:0] act_valid;
        logic [2:0] rec_sel;
        logic rec_armed;
        logic rec_busy;
        logic rec_start;
        logic [NUM_GEN-1:0][7:0] start_mode;
        logic [NUM_GEN-1:0][7:0] rate;
        logic [NUM_GEN-1:0][7:0] rate_cnt;
        logic [NUM_GEN-1:0][15:0] cycles;
        logic [NUM_GEN-1:0][15:0] len;
        logic [NUM_GEN-1:0][15:0] pt_cnt;
        logic [NUM_GEN-1:0][15:0] cyc_cnt;
        logic [NUM_GEN-1:0] step;
        logic [NUM_GEN-1:0] done;
        logic err;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    // everything volatile: reset clears all; zero rate and length act as one
    localparam state_t STATE_RST = '0;

endpackage

// ==== hw/trig_in_unit.sv ====
// trigger-input unit: four digital lines steering recorder and two wave generators
// assumes an apb master on clk_sys_i and asynchronous trigger lines from outside
//
// The implementer's own choices: the APB slave port and the register addresses.

////////////////////////////////////////////////////////////////////////////////
module trig_in_unit
    import trig_in_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    // trigger lines from outside
    input wire logic [NUM_LINES-1:0] line_i,
    // recorder
    input wire logic rec_done_i,
    output logic rec_start_o,
    // wave generators
    output logic [NUM_GEN-1:0] wg_step_o,
    output logic [NUM_GEN-1:0] wg_done_o
);

    state_t s;
    state_t n;
    logic [NUM_LINES-1:0] act;
    logic [NUM_LINES-1:0] fire;
    logic [NUM_GEN-1:0] inc;
    logic rec_fire;
    logic access;
    logic taking;
    logic set_wr;
    logic set_ok;
    logic act_wr;
    logic mode_wr;
    logic [7:0] set_line;
    logic [7:0] set_param;
    logic [7:0] set_val;
    logic [1:0] set_idx;
    logic [31:0] rd_data;
    logic [7:0] rate_eff [NUM_GEN];
    logic [15:0] len_eff [NUM_GEN];

    // line ids feed a two-bit index and the mask field must hold every generator
    if ((NUM_LINES > 4) || (CFG_MASK_LSB + NUM_GEN > CFG_W))
    begin
        $error("unsupported line or generator count");
    end

    function automatic logic is_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_LAST);
    endfunction

    function automatic logic [2:0] func_of(input logic [CFG_W-1:0] c);
        return c[CFG_FUNC_LSB +: 3];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        n = s;
        n.sync1 = line_i;
        n.sync2 = s.sync1;
        n.rec_start = 1'b0;
        n.step = '0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;

        access = psel_i && penable_i;
        taking = access && s.pready && pwrite_i && is_mapped(paddr_i);
        set_line = pwdata_i[SET_LINE_LSB +: 8];
        set_param = pwdata_i[SET_PARAM_LSB +: 8];
        set_val = pwdata_i[SET_VAL_LSB +: 8];
        set_idx = 2'(set_line - 8'h01);
        set_wr = taking && (paddr_i == OFS_SETTING);
        act_wr = taking && (paddr_i == OFS_ACTIVATE);
        mode_wr = taking && (paddr_i == OFS_WG_MODE);

        // value check per setting id; bad words leave the staged copy alone
        set_ok = 1'b0;
        if ((set_line >= 8'h01) && (set_line <= 8'(NUM_LINES)))
        begin
            case (set_param)
                PARAM_EDGE_LEVEL: set_ok = (set_val <= 8'h01);
                PARAM_FUNCTION: set_ok = (set_val == 8'h00) || (set_val == 8'h02)
                                         || (set_val == 8'h04);
                PARAM_POLARITY: set_ok = (set_val <= 8'h01);
                PARAM_GEN_MASK: set_ok = (set_val <= MASK_MAX);
                default: set_ok = 1'b0;
            endcase
        end

        // line evaluation works only from the activated copy
        for (int i = 0; i < NUM_LINES; i++)
        begin
            act[i] = ~(s.sync2[i] ^ s.active[i][CFG_POL_BIT]);
            if (s.active[i][CFG_TYPE_BIT] == TYPE_EDGE)
                fire[i] = act[i] && !s.act_prev[i];
            else
                fire[i] = act[i];
            fire[i] = fire[i] && s.act_valid[i] && (func_of(s.active[i]) != FUNC_NONE);
        end
        n.act_prev = act;

        rec_fire = 1'b0;
        for (int i = 0; i < NUM_LINES; i++)
            if (fire[i] && (func_of(s.active[i]) == FUNC_CAPTURE)
                && (s.rec_sel == 3'(i + 1)))
                rec_fire = 1'b1;

        // one-shot capture start, then blocked until done and re-armed
        if (rec_fire && s.rec_armed && !s.rec_busy)
        begin
            n.rec_start = 1'b1;
            n.rec_armed = 1'b0;
            n.rec_busy = 1'b1;
        end
        else if (rec_done_i)
            n.rec_busy = 1'b0;

        for (int g = 0; g < NUM_GEN; g++)
        begin
            inc[g] = 1'b0;
            for (int i = 0; i < NUM_LINES; i++)
                if (fire[i] && (func_of(s.active[i]) == FUNC_WAVE)
                    && s.active[i][CFG_MASK_LSB + g]
                    && s.start_mode[g][WG_EXT_START_BIT])
                    inc[g] = 1'b1;
            rate_eff[g] = (s.rate[g] == 8'h00) ? 8'h01 : s.rate[g];
            len_eff[g] = (s.len[g] == 16'h0000) ? 16'h0001 : s.len[g];
        end

        // apb write, after the capture logic so that an arm write wins; stepping skips mode-write cycles
        if (set_wr)
        begin
            if (set_ok)
            begin
                case (set_param)
                    PARAM_EDGE_LEVEL: n.staged[set_idx][CFG_TYPE_BIT] = set_val[0];
                    PARAM_FUNCTION: n.staged[set_idx][CFG_FUNC_LSB +: 3] = set_val[2:0];
                    PARAM_POLARITY: n.staged[set_idx][CFG_POL_BIT] = set_val[0];
                    default: n.staged[set_idx][CFG_MASK_LSB +: 2] = set_val[1:0];
                endcase
            end
        end
        if (act_wr)
        begin
            for (int i = 0; i < NUM_LINES; i++)
                if (pwdata_i[i])
                begin
                    n.active[i] = s.staged[i];
                    n.act_valid[i] = 1'b1;
                end
        end
        if (taking && (paddr_i == OFS_REC_ARM))
        begin
            n.rec_sel = pwdata_i[2:0];
            if (pwdata_i[REC_ARM_BIT])
                n.rec_armed = 1'b1;
        end
        if (taking && (paddr_i == OFS_STATUS) && pwdata_i[STAT_ERR_BIT])
            n.err = 1'b0;
        if (set_wr && !set_ok)
            n.err = 1'b1;
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (mode_wr)
            begin
                // a start-mode write restarts the generator's counting
                n.start_mode[g] = pwdata_i[8 * g +: 8];
                n.rate_cnt[g] = 8'h00;
                n.pt_cnt[g] = 16'h0000;
                n.cyc_cnt[g] = 16'h0000;
                n.done[g] = 1'b0;
            end
            if (taking && (paddr_i == OFS_WG_RATE))
                n.rate[g] = pwdata_i[8 * g +: 8];
            if (taking && (paddr_i == OFS_WG_CYCLES))
                n.cycles[g] = pwdata_i[16 * g +: 16];
            if (taking && (paddr_i == OFS_WG_LEN))
                n.len[g] = pwdata_i[16 * g +: 16];
        end

        // generator stepping: edges count one each, a level counts each clock
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (inc[g] && !s.done[g] && !mode_wr)
            begin
                if (s.rate_cnt[g] >= rate_eff[g] - 8'h01)
                begin
                    n.rate_cnt[g] = 8'h00;
                    n.step[g] = 1'b1;
                    if (s.pt_cnt[g] >= len_eff[g] - 16'h0001)
                    begin
                        n.pt_cnt[g] = 16'h0000;
                        n.cyc_cnt[g] = s.cyc_cnt[g] + 16'h0001;
                        if ((s.cycles[g] != 16'h0000)
                            && (s.cyc_cnt[g] >= s.cycles[g] - 16'h0001))
                            n.done[g] = 1'b1;
                    end
                    else
                        n.pt_cnt[g] = s.pt_cnt[g] + 16'h0001;
                end
                else
                    n.rate_cnt[g] = s.rate_cnt[g] + 8'h01;
            end
        end

        // read mux; register answers one cycle into the access phase
        rd_data = 32'h0000_0000;
        case (paddr_i)
            OFS_ACTIVATE: rd_data[NUM_LINES-1:0] = s.act_valid;
            OFS_REC_ARM: rd_data[4:0] = {s.rec_busy, s.rec_armed, s.rec_sel};
            OFS_WG_MODE: rd_data[15:0] = s.start_mode;
            OFS_WG_RATE: rd_data[15:0] = s.rate;
            OFS_WG_CYCLES: rd_data = s.cycles;
            OFS_WG_LEN: rd_data = s.len;
            OFS_STATUS: rd_data[7:0] = {s.err, s.rec_busy, s.done, s.sync2};
            default:
            begin
                for (int i = 0; i < NUM_LINES; i++)
                    if (paddr_i == OFS_CFG_VIEW + 8'(4 * i))
                    begin
                        rd_data[CFG_W-1:0] = s.staged[i];
                        rd_data[VIEW_ACTIVE_LSB +: CFG_W] = s.active[i];
                    end
            end
        endcase
        if (access && !s.pready)
        begin
            n.pready = 1'b1;
            n.pslverr = !is_mapped(paddr_i);
            n.prdata = is_mapped(paddr_i) ? rd_data : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            s <= STATE_RST;
        else
            s <= n;
    end

    assign pready_o = s.pready;
    assign pslverr_o = s.pslverr;
    assign prdata_o = s.prdata;
    assign rec_start_o = s.rec_start;
    assign wg_step_o = s.step;
    assign wg_done_o = s.done;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // check-only count of gen1 events since its last point; mirrors no design counter
    logic [7:0] seen_inc;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i || mode_wr)
            seen_inc <= 8'h00;
        else if (inc[0] && !s.done[0])
            seen_inc <= (s.step[0] ? 8'h00 : seen_inc) + 8'h01;
        else if (s.step[0])
            seen_inc <= 8'h00;
    end

    rec_blocked_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.rec_start |-> $past(s.rec_armed) && !$past(s.rec_busy))
        else $error("capture started while busy or unarmed");

    rec_busy_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.rec_busy && !rec_done_i |=> s.rec_busy && !s.rec_start)
        else $error("recorder busy dropped or retriggered");

    staged_inert_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !act_wr |=> $stable(s.active))
        else $error("active config changed without activation");

    bad_setting_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        set_wr && !set_ok |=> $stable(s.staged) && s.err)
        else $error("invalid setting word was stored");

    sync_delay_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !$past(srst_i) && !$past(srst_i, 2) |-> s.sync2 == $past(line_i, 2))
        else $error("line synchroniser depth wrong");

    cycles_stop_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.done[0] && !mode_wr |=> !s.step[0] && s.done[0])
        else $error("generator stepped after cycle limit");

    level_pause_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !inc[1] |=> !s.step[1] && $stable(s.rate_cnt[1]) || $past(mode_wr))
        else $error("generator advanced without trigger");

    rate_count_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.step[0] |-> seen_inc == $past(rate_eff[0]))
        else $error("point emitted before rate reached");

    apb_ready_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        psel_i && penable_i && !s.pready |=> s.pready ##1 !s.pready)
        else $error("apb answer not a one-cycle pulse");

    apb_err_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.pslverr |-> s.pready)
        else $error("apb error flagged outside an answer");

    ext_start_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.step[0] |-> $past(s.start_mode[0][WG_EXT_START_BIT]))
        else $error("generator one stepped without external start");

    ext_start_two_a: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        s.step[1] |-> $past(s.start_mode[1][WG_EXT_START_BIT]))
        else $error("generator two stepped without external start");

endmodule

// ==== tb/trig_line_drv.sv ====
// partner model: outside equipment driving the four trigger lines
// assumes the bench hands it the system clock only to pace its changes
module trig_line_drv
    import trig_in_pkg::*;
(
    input wire logic clk_i,
    output logic [NUM_LINES-1:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // the equipment drives a true level at all times, idle low
    initial line_o = '0;

    // toggle one line for w cycles, then give the sync chain time to settle
    task automatic pulse(input int n, input int w);
        @(posedge clk_i);
        line_o[n-1] <= ~line_o[n-1];
        repeat (w) @(posedge clk_i);
        line_o[n-1] <= ~line_o[n-1];
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ==== tb/test_trig_in_unit.sv ====
// bench for the trigger-input unit: apb master, line driver, pulse counters
// assumes the apb slave answers in a bounded number of cycles
module test_trig_in_unit
    import trig_in_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [NUM_LINES-1:0] line;
    logic rec_done = 1'b0;
    logic rec_start;
    logic [NUM_GEN-1:0] wg_step;
    logic [NUM_GEN-1:0] wg_done;
    int mismatches = 0;
    int num_checks = 0;
    int n0 = 0;
    int n1 = 0;
    int nrec = 0;
    int s = 0;
    int s1 = 0;

    always #2.5 clk = ~clk;

    trig_in_unit dut (.clk_sys_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .pslverr_o(pslverr), .prdata_o(prdata), .line_i(line), .rec_done_i(rec_done),
        .rec_start_o(rec_start), .wg_step_o(wg_step), .wg_done_o(wg_done));

    trig_line_drv drv (.clk_i(clk), .line_o(line));

    // count one-cycle pulses so widened pulses show up as extra counts
    always @(posedge clk)
    begin
        n0 += (wg_step[0] === 1'b1);
        n1 += (wg_step[1] === 1'b1);
        nrec += (rec_start === 1'b1);
    end

    ////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following setup never re-drives psel in this step
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(nm, rd & m, exp);
    endtask

    task automatic cfg(input logic [7:0] ln, input logic [7:0] id, input logic [7:0] v);
        wr(OFS_SETTING, {8'h00, ln, id, v});
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] rd;
        logic er;
        rdchk("activated", OFS_ACTIVATE, 32'h0F, 32'h0);
        rdchk("view1", OFS_CFG_VIEW, 32'h007F007F, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0, rd, er);
        chk("status flags", rd & 32'h0000_00F0, 32'h0);
        chk("mapped err", {31'h0, er}, 32'h0);
        apb(1'b0, 8'h30, 32'h0, rd, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
    endtask

    task automatic t_edge;
        s = n0;
        wr(OFS_WG_MODE, 32'h0000_0202);
        cfg(8'h01, PARAM_FUNCTION, {5'h00, FUNC_WAVE});
        cfg(8'h01, PARAM_POLARITY, 8'h01);
        cfg(8'h01, PARAM_GEN_MASK, 8'h01);
        drv.pulse(1, 8);
        chk("step unactivated", n0 - s, 32'h0);
        rdchk("view1 staged", OFS_CFG_VIEW, 32'h007F007F, 32'h0000_0038);
        wr(OFS_ACTIVATE, 32'h1);
        drv.pulse(1, 8);
        drv.pulse(1, 1);
        chk("edge steps", n0 - s, 32'h2);
    endtask

    task automatic t_rate;
        s = n0;
        wr(OFS_WG_RATE, 32'h2);
        wr(OFS_WG_MODE, 32'h0000_0202);
        drv.pulse(1, 4);
        chk("rate first edge", n0 - s, 32'h0);
        drv.pulse(1, 4);
        chk("rate second edge", n0 - s, 32'h1);
        wr(OFS_WG_RATE, 32'h0);
    endtask

    task automatic t_pol;
        s = n0;
        s1 = n1;
        cfg(8'h02, PARAM_FUNCTION, {5'h00, FUNC_WAVE});
        cfg(8'h02, PARAM_GEN_MASK, 8'h02);
        wr(OFS_ACTIVATE, 32'h2);
        rdchk("activated", OFS_ACTIVATE, 32'h0F, 32'h3);
        drv.pulse(2, 6);
        chk("gen2 steps", n1 - s1, 32'h1);
        chk("gen1 idle", n0 - s, 32'h0);
    endtask

    task automatic t_level;
        s = n0;
        cfg(8'h03, PARAM_EDGE_LEVEL, 8'h01);
        cfg(8'h03, PARAM_FUNCTION, {5'h00, FUNC_WAVE});
        cfg(8'h03, PARAM_POLARITY, 8'h01);
        cfg(8'h03, PARAM_GEN_MASK, 8'h01);
        wr(OFS_ACTIVATE, 32'h4);
        wr(OFS_WG_MODE, 32'h0000_0202);
        drv.pulse(3, 10);
        chk("level steps", n0 - s, 32'hA);
        wr(OFS_WG_LEN, 32'h2);
        wr(OFS_WG_CYCLES, 32'h1);
        wr(OFS_WG_MODE, 32'h0000_0202);
        s = n0;
        drv.pulse(3, 20);
        chk("limited steps", n0 - s, 32'h2);
        chk("gen done", {30'h0, wg_done}, 32'h1);
    endtask

    task automatic t_capture;
        s = nrec;
        cfg(8'h04, PARAM_FUNCTION, {5'h00, FUNC_CAPTURE});
        cfg(8'h04, PARAM_POLARITY, 8'h01);
        wr(OFS_ACTIVATE, 32'h8);
        wr(OFS_REC_ARM, 32'h0000_000C);
        drv.pulse(4, 4);
        chk("capture start", nrec - s, 32'h1);
        rdchk("rec busy", OFS_STATUS, 32'h40, 32'h40);
        drv.pulse(4, 4);
        chk("busy ignores", nrec - s, 32'h1);
        rec_done <= 1'b1;
        @(posedge clk);
        rec_done <= 1'b0;
        drv.pulse(4, 4);
        chk("unarmed ignores", nrec - s, 32'h1);
        wr(OFS_REC_ARM, 32'h0000_000C);
        drv.pulse(4, 4);
        chk("rearmed start", nrec - s, 32'h2);
    endtask

    task automatic t_errs;
        cfg(8'h05, PARAM_POLARITY, 8'h01);
        rdchk("err bad line", OFS_STATUS, 32'h80, 32'h80);
        wr(OFS_STATUS, 32'h80);
        cfg(8'h01, 8'h02, 8'h00);
        rdchk("err bad id", OFS_STATUS, 32'h80, 32'h80);
        s = n0;
        cfg(8'h01, PARAM_FUNCTION, {5'h00, FUNC_NONE});
        wr(OFS_ACTIVATE, 32'h1);
        // restart gen1, left done by the level test's cycle limit, so it could step
        wr(OFS_WG_MODE, 32'h0000_0202);
        drv.pulse(1, 4);
        chk("disabled line", n0 - s, 32'h0);
        // a second reset must wipe every setting
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdchk("view3 after reset", OFS_CFG_VIEW + 8'h08, 32'h007F007F, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_edge();
        t_rate();
        t_pol();
        t_level();
        t_capture();
        t_errs();
        report_and_stop();
    end

    // the whole run needs about 400 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
